// File: rtl/sev_register_map.sv
// register map and event flags of the pressure/temperature sensor
// assumes a serial engine hands over byte reads and writes on sys_clk
`timescale 1ns/1ps
`default_nettype none
module sev_register_map #(
  parameter logic [7:0] ID_CODE = sev_pkg::ID_CODE, // arbitrary value
  parameter int         Q_DEPTH = sev_pkg::Q_DEPTH
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // byte access from the serial engine
  input  wire logic        reg_start,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // acquisition side
  input  wire logic        active_req,
  input  wire logic        smp_valid,
  input  wire logic [19:0] smp_press,
  input  wire logic [11:0] smp_temp,
  input  wire logic [15:0] pressure_window,
  // derived values
  output logic      [16:0] sea_level_ref_pa,
  output logic      [19:0] press_min,
  output logic      [19:0] press_max,
  output logic      [11:0] temp_min,
  output logic      [11:0] temp_max
);
  sev_smp_if smp ();
  logic        active_q;
  logic        entry;
  logic [7:0]  ptr_q;
  logic [19:0] press_q;
  logic [11:0] temp_q;
  logic [7:0]  dr_q;
  logic [7:0]  dr_set;
  logic [7:0]  dr_clr;
  logic [7:0]  setup_q;
  logic [7:0]  elapsed_q;
  logic [7:0]  opstate_q;
  logic [7:0]  src_q;
  logic [7:0]  cfg_q;
  logic [15:0] ref_q;
  logic [15:0] ptgt_q;
  logic [7:0]  ttgt_q;
  logic [19:0] dp;
  logic [11:0] dt;
  logic        pchg;
  logic        tchg;
  logic        q_on;
  logic        q_pop;
  logic [7:0]  q_byte;
  logic [5:0]  q_count;
  logic        q_ovf;
  logic        q_wmk;
  logic [7:0]  q_status;
  logic [7:0]  ev_src;
  logic [7:0]  rd_byte;
  logic        rd_at;

  assign smp.press = smp_press;
  assign smp.temp  = smp_temp;
  assign smp.valid = smp_valid;

  sev_change_det u_det (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clr     (entry),
    .smp     (smp),
    .window  (pressure_window),
    .dp_q    (dp),
    .dt_q    (dt),
    .pchg    (pchg),
    .tchg    (tchg),
    .pmin_q  (press_min),
    .pmax_q  (press_max),
    .tmin_q  (temp_min),
    .tmax_q  (temp_max)
  );

  sev_sample_queue #(.DEPTH(Q_DEPTH)) u_queue (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clr      (entry),
    .smp      (smp),
    .mode     (setup_q[sev_pkg::QS_MODE_LO +: 2]),
    .mark     (setup_q[5:0]),
    .pop      (q_pop),
    .byte_out (q_byte),
    .count_q  (q_count),
    .ovf_q    (q_ovf),
    .wmk      (q_wmk)
  );

  // next pointer value after one byte of a burst
  function automatic logic [7:0] next_ptr(input logic [7:0] a,
                                          input logic       qon);
    case (a)
      sev_pkg::A_T_LO:  next_ptr = sev_pkg::A_STATUS;
      sev_pkg::A_DT_LO: next_ptr = sev_pkg::A_DRSTAT;
      sev_pkg::A_QDATA: next_ptr = sev_pkg::A_QDATA;
      sev_pkg::A_P_HI:  next_ptr = qon ? a : 8'(a + 8'h01);
      default:          next_ptr = 8'(a + 8'h01);
    endcase
  endfunction

  // decode of the current pointer, used for reads and read side effects
  function automatic logic is_at(input logic [7:0] p, input logic [7:0] a);
    return p == a;
  endfunction

  // standby-to-active edge; the request comes from same-clock control logic
  assign entry = active_req & ~active_q;
  assign q_on  = setup_q[sev_pkg::QS_MODE_LO +: 2] != 2'b00;
  assign rd_at = reg_rd & ~reg_start;
  assign q_pop = rd_at & (is_at(ptr_q, sev_pkg::A_QDATA) |
                 (q_on & is_at(ptr_q, sev_pkg::A_P_HI)));
  assign q_status = {q_ovf, q_wmk, q_count};
  // data-ready source follows the status bits, never latched on its own
  assign ev_src = {src_q[7:1] & 7'h7F, src_q[0]} |
                  {dr_q[sev_pkg::DR_SAMPLE_OVERWRITE_FLAG] | dr_q[sev_pkg::DR_SAMPLE_NEW_FLAG], 7'h00};

  // read multiplexer
  always_comb begin
    case (ptr_q)
      sev_pkg::A_STATUS:  rd_byte = q_on ? q_status : dr_q;
      sev_pkg::A_P_HI:    rd_byte = q_on ? q_byte : press_q[19:12];
      sev_pkg::A_P_MID:   rd_byte = press_q[11:4];
      sev_pkg::A_P_LO:    rd_byte = {press_q[3:0], 4'h0};
      sev_pkg::A_T_HI:    rd_byte = temp_q[11:4];
      sev_pkg::A_T_LO:    rd_byte = {temp_q[3:0], 4'h0};
      sev_pkg::A_DRSTAT:  rd_byte = dr_q;
      sev_pkg::A_DP_HI:   rd_byte = dp[19:12];
      sev_pkg::A_DP_MID:  rd_byte = dp[11:4];
      sev_pkg::A_DP_LO:   rd_byte = {dp[3:0], 4'h0};
      sev_pkg::A_DT_HI:   rd_byte = dt[11:4];
      sev_pkg::A_DT_LO:   rd_byte = {dt[3:0], 4'h0};
      sev_pkg::A_IDENT:   rd_byte = ID_CODE;
      sev_pkg::A_QSTAT:   rd_byte = q_status;
      sev_pkg::A_QDATA:   rd_byte = q_byte;
      sev_pkg::A_QSETUP:  rd_byte = setup_q;
      sev_pkg::A_ELAPSED: rd_byte = elapsed_q;
      sev_pkg::A_OPSTATE: rd_byte = opstate_q;
      sev_pkg::A_EVSRC:   rd_byte = ev_src;
      sev_pkg::A_EVCFG:   rd_byte = cfg_q;
      sev_pkg::A_REF_HI:  rd_byte = ref_q[15:8];
      sev_pkg::A_REF_LO:  rd_byte = ref_q[7:0];
      sev_pkg::A_PTGT_HI: rd_byte = ptgt_q[15:8];
      sev_pkg::A_PTGT_LO: rd_byte = ptgt_q[7:0];
      sev_pkg::A_TTGT:    rd_byte = ttgt_q;
      default:            rd_byte = sev_pkg::RST_ZERO;
    endcase
  end

  // address pointer and read data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr_q <= sev_pkg::A_STATUS;
      reg_rdata <= sev_pkg::RST_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_at;
      if (rd_at) reg_rdata <= rd_byte;
      if (reg_start) ptr_q <= reg_addr;
      else if (reg_rd || reg_wr) ptr_q <= next_ptr(ptr_q, q_on);
    end
  end

  // mode tracking; only the entry into active clears anything
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_q <= 1'b0;
      opstate_q <= sev_pkg::RST_ZERO;
    end else begin
      active_q <= active_req;
      if (entry) opstate_q <= sev_pkg::RST_ZERO;
      else opstate_q <= {7'h00, active_q};
    end
  end

  // latest sample, cleared on entry and kept when going idle
  always_ff @(posedge sys_clk) begin
    if (rst || entry) begin
      press_q <= '0;
      temp_q <= '0;
    end else if (smp_valid) begin
      press_q <= smp_press;
      temp_q <= smp_temp;
    end
  end

  // sample-ready flags: reading the high byte of a value acknowledges it
  always_comb begin
    dr_set = 8'h00;
    dr_clr = 8'h00;
    if (smp_valid) begin
      dr_set[sev_pkg::DR_TDR] = 1'b1;
      dr_set[sev_pkg::DR_PDR] = 1'b1;
      dr_set[sev_pkg::DR_SAMPLE_NEW_FLAG] = 1'b1;
      dr_set[sev_pkg::DR_TOW] = dr_q[sev_pkg::DR_TDR];
      dr_set[sev_pkg::DR_POW] = dr_q[sev_pkg::DR_PDR];
      dr_set[sev_pkg::DR_SAMPLE_OVERWRITE_FLAG] = dr_q[sev_pkg::DR_SAMPLE_NEW_FLAG];
    end
    if (rd_at && !q_on && is_at(ptr_q, sev_pkg::A_P_HI)) begin
      dr_clr[sev_pkg::DR_PDR] = 1'b1;
      dr_clr[sev_pkg::DR_POW] = 1'b1;
      dr_clr[sev_pkg::DR_SAMPLE_NEW_FLAG] = 1'b1;
      dr_clr[sev_pkg::DR_SAMPLE_OVERWRITE_FLAG] = 1'b1;
    end
    if (rd_at && is_at(ptr_q, sev_pkg::A_T_HI)) begin
      dr_clr[sev_pkg::DR_TDR] = 1'b1;
      dr_clr[sev_pkg::DR_TOW] = 1'b1;
      dr_clr[sev_pkg::DR_SAMPLE_NEW_FLAG] = 1'b1;
      dr_clr[sev_pkg::DR_SAMPLE_OVERWRITE_FLAG] = 1'b1;
    end
  end

  // a sample landing on the acknowledging read still sets its flag
  always_ff @(posedge sys_clk) begin
    if (rst || entry) dr_q <= sev_pkg::RST_ZERO;
    else dr_q <= (dr_q & ~dr_clr) | dr_set;
  end

  // pending sources: sticky, cleared by reading 12h, set beats clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_q <= sev_pkg::RST_ZERO;
    end else begin
      if (rd_at && is_at(ptr_q, sev_pkg::A_EVSRC)) src_q <= 8'h00;
      if (pchg && cfg_q[sev_pkg::CFG_PRESS])
        src_q[sev_pkg::EV_PCHG] <= 1'b1;
      if (tchg && cfg_q[sev_pkg::CFG_TEMP])
        src_q[sev_pkg::EV_TCHG] <= 1'b1;
      if (q_ovf || q_wmk) src_q[sev_pkg::EV_QUEUE] <= 1'b1;
    end
  end

  // samples taken since overflow, saturating; one count per acquisition
  always_ff @(posedge sys_clk) begin
    if (rst || entry) elapsed_q <= sev_pkg::RST_ZERO;
    else if (smp_valid && q_ovf && elapsed_q != sev_pkg::SAT_TIME)
      elapsed_q <= elapsed_q + 8'h01;
  end

  // writable setup and reference registers, kept across mode changes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      setup_q <= sev_pkg::RST_ZERO;
      cfg_q <= sev_pkg::RST_ZERO;
      ref_q <= {sev_pkg::RST_REF_HI, sev_pkg::RST_REF_LO};
      ptgt_q <= '0;
      ttgt_q <= sev_pkg::RST_ZERO;
    end else if (reg_wr && !reg_start) begin
      case (ptr_q)
        sev_pkg::A_QSETUP:  setup_q <= reg_wdata;
        sev_pkg::A_EVCFG:   cfg_q <= reg_wdata;
        sev_pkg::A_REF_HI:  ref_q[15:8] <= reg_wdata;
        sev_pkg::A_REF_LO:  ref_q[7:0] <= reg_wdata;
        sev_pkg::A_PTGT_HI: ptgt_q[15:8] <= reg_wdata;
        sev_pkg::A_PTGT_LO: ptgt_q[7:0] <= reg_wdata;
        sev_pkg::A_TTGT:    ttgt_q <= reg_wdata;
        default:            ;
      endcase
    end
  end

  // reference scaled to pascals for the altitude path
  always_ff @(posedge sys_clk) begin
    if (rst) sea_level_ref_pa <= '0;
    else sea_level_ref_pa <= {ref_q, 1'b0};
  end

  // checks
  chk_new_sample_flag: assert property (@(posedge sys_clk) disable iff (rst)
    smp_valid && !entry |=> dr_q[sev_pkg::DR_SAMPLE_NEW_FLAG] && ev_src[7])
    else $error("new sample did not raise data ready");
  chk_overwrite_flag: assert property (@(posedge sys_clk) disable iff (rst)
    smp_valid && !entry && dr_q[sev_pkg::DR_SAMPLE_NEW_FLAG]
    |=> dr_q[sev_pkg::DR_SAMPLE_OVERWRITE_FLAG])
    else $error("overwrite not flagged");
  chk_drdy_source: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(dr_q[sev_pkg::DR_SAMPLE_NEW_FLAG]) && !dr_q[sev_pkg::DR_SAMPLE_OVERWRITE_FLAG]
    |-> !ev_src[sev_pkg::EV_DRDY])
    else $error("data ready source without status bits");
  chk_press_change: assert property (@(posedge sys_clk) disable iff (rst)
    pchg && cfg_q[sev_pkg::CFG_PRESS] |=> src_q[sev_pkg::EV_PCHG])
    else $error("pressure change not flagged");
  chk_temp_change: assert property (@(posedge sys_clk) disable iff (rst)
    tchg && cfg_q[sev_pkg::CFG_TEMP] |=> src_q[sev_pkg::EV_TCHG])
    else $error("temperature change not flagged");
  chk_wrap_05: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at && ptr_q == sev_pkg::A_T_LO |=> ptr_q == sev_pkg::A_STATUS)
    else $error("pointer did not wrap after 05h");
  chk_wrap_0b: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at && ptr_q == sev_pkg::A_DT_LO |=> ptr_q == sev_pkg::A_DRSTAT)
    else $error("pointer did not wrap after 0Bh");
  chk_queue_hold: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at && (ptr_q == sev_pkg::A_QDATA || (q_on && ptr_q == 8'h01))
    |=> $stable(ptr_q))
    else $error("queue pointer moved");
  chk_entry_clear: assert property (@(posedge sys_clk) disable iff (rst)
    entry |=> opstate_q == 8'h00 && press_q == '0 && elapsed_q == 8'h00
    ##1 opstate_q == 8'h01)
    else $error("entry to active did not clear");
  chk_cfg_write: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && !reg_start && ptr_q == sev_pkg::A_EVCFG
    |=> cfg_q == $past(reg_wdata))
    else $error("config write lost");
  chk_read_latency: assert property (@(posedge sys_clk) disable iff (rst)
    rd_at && ptr_q == sev_pkg::A_IDENT |=> reg_rvalid && reg_rdata == ID_CODE)
    else $error("identity read wrong");
  cov_burst_wrap: cover property (@(posedge sys_clk) disable iff (rst)
    rd_at && ptr_q == sev_pkg::A_T_LO ##1 rd_at);
  cov_overwrite: cover property (@(posedge sys_clk) disable iff (rst)
    dr_q[sev_pkg::DR_SAMPLE_OVERWRITE_FLAG]);
  cov_queue_ovf: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(q_ovf));
endmodule
`default_nettype wire

// File: rtl/sev_pkg.sv
// constants shared by the sensor event register map and its helpers
// assumes a single 25 MHz clock and a synchronous active-high reset
//
// Overview of operation
// - set pressure change flag when successive pressure samples differ beyond window
// - set temperature change flag when successive temperature samples differ beyond window
// - set data-ready flag on new sample or overwrite of unread sample
// - data-ready source is live only while overwrite or new-sample flag set
// - queue event flag sets on queue overflow or watermark reached
// - read-only pressure delta at 07h-09h, temperature delta 0Ah-0Bh
// - track minimum and maximum pressure and temperature across samples
// - address 00h reads sample-ready status or queue status by queue use
// - 20-bit pressure sample split over 01h, 02h and 03h
// - 12-bit temperature sample split over 04h and 05h
// - pointer advances per byte; 05h wraps to 00h, 0Bh wraps to 06h
// - with queue in use 01h is queue root and pointer stays there
// - 0Eh gives queued bytes and pointer stays at 0Eh
// - 10h reports elapsed time since queue overflow
// - 11h reports operating state, cleared on entry to active
// - 12h reports pending sources, kept across standby-to-active
// - writable 13h, reset 00h, picks which data events raise flags
// - 16-bit writable sea level reference at 14h/15h, low resets E7h
// - 16-bit writable pressure target at 16h/17h, resetting 00h
// - 8-bit writable temperature target at 18h, resetting 00h
// - fixed read-only identity code at 0Ch, never cleared
// - writable queue setup 0Fh, read-only queue status 0Dh reading 00h idle
// - flagged registers clear entering active, keep contents entering standby
// - sea level reference counts two pascals per bit
package sev_pkg;
  // register addresses
  localparam logic [7:0] A_STATUS  = 8'h00;
  localparam logic [7:0] A_P_HI    = 8'h01;
  localparam logic [7:0] A_P_MID   = 8'h02;
  localparam logic [7:0] A_P_LO    = 8'h03;
  localparam logic [7:0] A_T_HI    = 8'h04;
  localparam logic [7:0] A_T_LO    = 8'h05;
  localparam logic [7:0] A_DRSTAT  = 8'h06;
  localparam logic [7:0] A_DP_HI   = 8'h07;
  localparam logic [7:0] A_DP_MID  = 8'h08;
  localparam logic [7:0] A_DP_LO   = 8'h09;
  localparam logic [7:0] A_DT_HI   = 8'h0A;
  localparam logic [7:0] A_DT_LO   = 8'h0B;
  localparam logic [7:0] A_IDENT   = 8'h0C;
  localparam logic [7:0] A_QSTAT   = 8'h0D;
  localparam logic [7:0] A_QDATA   = 8'h0E;
  localparam logic [7:0] A_QSETUP  = 8'h0F;
  localparam logic [7:0] A_ELAPSED = 8'h10;
  localparam logic [7:0] A_OPSTATE = 8'h11;
  localparam logic [7:0] A_EVSRC   = 8'h12;
  localparam logic [7:0] A_EVCFG   = 8'h13;
  localparam logic [7:0] A_REF_HI  = 8'h14;
  localparam logic [7:0] A_REF_LO  = 8'h15;
  localparam logic [7:0] A_PTGT_HI = 8'h16;
  localparam logic [7:0] A_PTGT_LO = 8'h17;
  localparam logic [7:0] A_TTGT    = 8'h18;
  // reset values
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_REF_HI = 8'hC5;
  localparam logic [7:0] RST_REF_LO = 8'hE7;
  localparam logic [7:0] SAT_TIME   = 8'hFF;
  // arbitrary identity value, not tied to any part
  localparam logic [7:0] ID_CODE    = 8'h5A;
  // sample-ready status bits
  localparam int DR_TDR = 1;
  localparam int DR_PDR = 2;
  localparam int DR_SAMPLE_NEW_FLAG = 3;
  localparam int DR_TOW = 5;
  localparam int DR_POW = 6;
  localparam int DR_SAMPLE_OVERWRITE_FLAG = 7;
  // event source bits
  localparam int EV_TCHG = 0;
  localparam int EV_PCHG = 1;
  localparam int EV_QUEUE = 6;
  localparam int EV_DRDY = 7;
  // event flag config bits
  localparam int CFG_TEMP = 0;
  localparam int CFG_PRESS = 1;
  // queue setup fields and depth
  localparam int QS_MODE_LO = 6;
  localparam logic [1:0] QM_WRAP = 2'b01;
  localparam int Q_DEPTH = 32;
  localparam int Q_BYTES = 5;
endpackage

// File: rtl/sev_smp_if.sv
// carrier for one finished acquisition inside the register map
// assumes producer and consumers share sys_clk
`timescale 1ns/1ps
`default_nettype none
interface sev_smp_if;
  logic [19:0] press;
  logic [11:0] temp;
  logic        valid;
  modport src (output press, temp, valid);
  modport dst (input press, temp, valid);
endinterface
`default_nettype wire

// File: rtl/sev_change_det.sv
// deltas, change events and min/max tracking for each acquisition
// assumes samples arrive as one-cycle strobes on sys_clk
`timescale 1ns/1ps
`default_nettype none
module sev_change_det (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clr,
  // samples and threshold
  sev_smp_if.dst           smp,
  input  wire logic [15:0] window,
  // results
  output logic      [19:0] dp_q,
  output logic      [11:0] dt_q,
  output logic             pchg,
  output logic             tchg,
  output logic      [19:0] pmin_q,
  output logic      [19:0] pmax_q,
  output logic      [11:0] tmin_q,
  output logic      [11:0] tmax_q
);
  logic        seen_q;
  logic [19:0] dp_d;
  logic [11:0] dt_d;
  logic [19:0] pmag;
  logic [11:0] tmag;
  logic [19:0] prev_p_q;
  logic [11:0] prev_t_q;
  // the first sample after entry has nothing to compare against
  assign dp_d = smp.press - prev_p_q;
  assign dt_d = smp.temp - prev_t_q;
  assign pmag = dp_d[19] ? 20'(-dp_d) : dp_d;
  assign tmag = dt_d[11] ? 12'(-dt_d) : dt_d;
  assign pchg = smp.valid & seen_q & (pmag > {4'h0, window});
  assign tchg = smp.valid & seen_q & (tmag > {4'h0, window[11:0]});
  // previous sample and deltas
  always_ff @(posedge sys_clk) begin
    if (rst || clr) begin
      seen_q <= 1'b0;
      prev_p_q <= '0;
      prev_t_q <= '0;
      dp_q <= '0;
      dt_q <= '0;
    end else if (smp.valid) begin
      seen_q <= 1'b1;
      prev_p_q <= smp.press;
      prev_t_q <= smp.temp;
      dp_q <= seen_q ? dp_d : '0;
      dt_q <= seen_q ? dt_d : '0;
    end
  end
  // extremes restart with the first sample after reset or entry to active
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pmin_q <= '0;
      pmax_q <= '0;
      tmin_q <= '0;
      tmax_q <= '0;
    end else if (smp.valid) begin
      if (!seen_q || smp.press < pmin_q) pmin_q <= smp.press;
      if (!seen_q || smp.press > pmax_q) pmax_q <= smp.press;
      if (!seen_q || smp.temp < tmin_q) tmin_q <= smp.temp;
      if (!seen_q || smp.temp > tmax_q) tmax_q <= smp.temp;
    end
  end
endmodule
`default_nettype wire

// File: rtl/sev_sample_queue.sv
// sample queue read out one byte at a time
// assumes pops come only from register reads on sys_clk
`timescale 1ns/1ps
`default_nettype none
module sev_sample_queue #(
  parameter int DEPTH = sev_pkg::Q_DEPTH
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clr,
  // fill side and setup
  sev_smp_if.dst          smp,
  input  wire logic [1:0] mode,
  input  wire logic [5:0] mark,
  // drain side
  input  wire logic       pop,
  output logic      [7:0] byte_out,
  output logic      [5:0] count_q,
  output logic            ovf_q,
  output logic            wmk
);
  localparam int AW = $clog2(DEPTH);
  logic [39:0]   mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [2:0]    bi_q;
  logic          full;
  logic          push;
  logic          word_done;
  logic [39:0]   head;
  assign full = count_q == 6'(DEPTH);
  assign push = smp.valid && mode != 2'b00 && (!full || mode == sev_pkg::QM_WRAP);
  assign head = mem[rp_q];
  assign word_done = pop && count_q != 6'h00 && bi_q == 3'(sev_pkg::Q_BYTES - 1);
  assign wmk = mark != 6'h00 && count_q >= mark;
  // bytes leave high first; empty queue reads zero
  always_comb begin
    case (bi_q)
      3'd0: byte_out = head[39:32];
      3'd1: byte_out = head[31:24];
      3'd2: byte_out = head[23:16];
      3'd3: byte_out = head[15:8];
      default: byte_out = head[7:0];
    endcase
    if (count_q == 6'h00) byte_out = 8'h00;
  end
  // storage is not reset, only the pointers, byte index, fill level and overflow flag are
  always_ff @(posedge sys_clk) begin
    if (push) mem[wp_q] <= {smp.press, smp.temp, 8'h00};
  end
  // pointers, byte index and fill level
  always_ff @(posedge sys_clk) begin
    if (rst || clr) begin
      wp_q <= '0;
      rp_q <= '0;
      bi_q <= '0;
      count_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (smp.valid && mode != 2'b00 && full) ovf_q <= 1'b1;
      if (pop && count_q != 6'h00) bi_q <= word_done ? 3'd0 : bi_q + 3'd1;
      // wrapping onto a full queue drops the oldest word
      if (word_done || (push && full)) rp_q <= rp_q + 1'b1;
      if (push && !full && !word_done) count_q <= count_q + 6'h01;
      else if (word_done && !(push && full) && !push) count_q <= count_q - 6'h01;
    end
  end
endmodule
`default_nettype wire

// File: test/sev_host_model.sv
// host side model: byte strobes of the register port
// assumes the register map samples its inputs on rising sys_clk
`timescale 1ns/1ps
`default_nettype none
module sev_host_model (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic            reg_start,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // idle strobes from time zero
  initial begin
    reg_start = 1'b0;
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // load pointer; bursts start at the high byte
  task automatic point(input logic [7:0] a);
    @(negedge sys_clk);
    reg_start = 1'b1;
    reg_addr  = a;
    @(negedge sys_clk);
    reg_start = 1'b0;
  endtask
  // one byte write at the pointer
  task automatic put(input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr    = 1'b1;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  // one byte read; ok stays low if no answer in four cycles
  task automatic get(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d  = 8'h00;
    @(negedge sys_clk);
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!ok && reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata;
      end
      if (!ok) @(negedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: test/tb_sev_register_map.sv
// testbench of the sensor register map, driven through the host model
// assumes one 25 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_sev_register_map;
  logic        sys_clk;
  logic        rst;
  logic        active_req;
  logic        smp_valid;
  logic [19:0] smp_press;
  logic [11:0] smp_temp;
  logic [15:0] pressure_window;
  wire  logic  reg_start, reg_wr, reg_rd, reg_rvalid;
  wire  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire  logic [16:0] sea_level_ref_pa;
  wire  logic [19:0] press_max, press_min;
  wire  logic [11:0] temp_min, temp_max;
  logic [7:0]  rb;
  logic        ok;
  int          miscompares;
  int          n_tests;

  sev_register_map sev_register_map_i (.sys_clk(sys_clk), .rst(rst),
    .reg_start(reg_start), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .active_req(active_req),
    .smp_valid(smp_valid), .smp_press(smp_press), .smp_temp(smp_temp),
    .pressure_window(pressure_window), .sea_level_ref_pa(sea_level_ref_pa),
    .press_min(press_min), .press_max(press_max), .temp_min(temp_min),
    .temp_max(temp_max));
  sev_host_model sev_host_model_i (.sys_clk(sys_clk), .reg_start(reg_start),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // 40 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read at the pointer and compare; a missing answer ends the run
  task automatic rdc(input logic [7:0] exp);
    sev_host_model_i.get(rb, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: no read answer", $time);
      close_out();
    end
    chk({24'h0000, rb}, {24'h0000, exp});
  endtask
  // one acquisition strobe, then a cycle for the update to land
  task automatic smp(input logic [19:0] p, input logic [11:0] t);
    @(negedge sys_clk);
    smp_valid = 1'b1;
    smp_press = p;
    smp_temp  = t;
    @(negedge sys_clk);
    smp_valid = 1'b0;
    @(negedge sys_clk);
  endtask

  initial begin
    rst = 1'b1;
    active_req = 1'b0;
    smp_valid = 1'b0;
    smp_press = 20'h0_0000;
    smp_temp = 12'h000;
    pressure_window = 16'h0100;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    // reset values, writes, read-only identity
    sev_host_model_i.point(8'h13);
    rdc(8'h00);
    rdc(sev_pkg::RST_REF_HI);
    rdc(8'hE7);
    rdc(8'h00);
    rdc(8'h00);
    rdc(8'h00);
    sev_host_model_i.point(8'h0C);
    sev_host_model_i.put(8'hFF);
    sev_host_model_i.point(8'h0C);
    rdc(sev_pkg::ID_CODE);
    sev_host_model_i.point(8'h13);
    sev_host_model_i.put(8'h03);
    sev_host_model_i.put(8'h12);
    sev_host_model_i.put(8'h34);
    sev_host_model_i.point(8'h14);
    rdc(8'h12);
    rdc(8'h34);
    chk({15'h0000, sea_level_ref_pa}, 32'h0000_2468);
    $display("test registers done");
    // entry to active, samples, burst wraps
    @(negedge sys_clk);
    active_req = 1'b1;
    repeat (3) @(negedge sys_clk);
    sev_host_model_i.point(8'h11);
    rdc(8'h01);
    smp(20'hA_BCDE, 12'h789);
    sev_host_model_i.point(8'h06);
    rdc(8'h0E);
    sev_host_model_i.point(8'h01);
    rdc(8'hAB);
    rdc(8'hCD);
    rdc(8'hE0);
    rdc(8'h78);
    rdc(8'h90);
    rdc(8'h00);
    @(negedge sys_clk);
    pressure_window = 16'h0010;
    smp(20'hA_BE01, 12'h79A);
    sev_host_model_i.point(8'h07);
    rdc(8'h00);
    rdc(8'h12);
    rdc(8'h30);
    rdc(8'h01);
    rdc(8'h10);
    rdc(8'h0E);
    sev_host_model_i.point(8'h12);
    rdc(8'h83);
    sev_host_model_i.point(8'h12);
    rdc(8'h80);
    chk({12'h000, press_max}, 32'h000A_BE01);
    chk({12'h000, press_min}, 32'h000A_BCDE);
    chk({20'h0_0000, temp_min}, 32'h0000_0789);
    chk({20'h0_0000, temp_max}, 32'h0000_079A);
    $display("test samples done");
    // queue on, watermark 1, drain through a fixed pointer
    sev_host_model_i.point(8'h0F);
    sev_host_model_i.put(8'h41);
    smp(20'h1_2345, 12'hABC);
    sev_host_model_i.point(8'h0D);
    rdc(8'h41);
    rdc(8'h12);
    rdc(8'h34);
    rdc(8'h5A);
    rdc(8'hBC);
    rdc(8'h00);
    // standby then active again: samples clear, reference kept
    @(negedge sys_clk);
    active_req = 1'b0;
    repeat (2) @(negedge sys_clk);
    active_req = 1'b1;
    repeat (3) @(negedge sys_clk);
    sev_host_model_i.point(8'h04);
    rdc(8'h00);
    sev_host_model_i.point(8'h14);
    rdc(8'h12);
    $display("test queue and entry done");
    close_out();
  end
endmodule
`default_nettype wire
